// ### logic/msw_consts.svh
// Constants for the multi-stage watchdog
`ifndef MSW_CONSTS_SVH
`define MSW_CONSTS_SVH
`define MSW_STAGES 4
`define MSW_CNT_W 32
`define MSW_KEY 32'h5a5a_a5a5
`define MSW_BOOT_TIMEOUT_DEF 32'h0100_0000
`define MSW_STAGE_TIMEOUT_DEF 32'h0010_0000
`define MSW_ACT_NONE 3'h0
`define MSW_ACT_INT 3'h1
`define MSW_ACT_CPU 3'h2
`define MSW_ACT_CORE 3'h3
`define MSW_ACT_SYS 3'h4
`endif

// ### logic/msw_pkg.sv
// Types for the multi-stage watchdog
package msw_pkg;
  typedef enum logic [2:0] {
    MSW_NONE = 3'h0,
    MSW_INT = 3'h1,
    MSW_CPU = 3'h2,
    MSW_CORE = 3'h3,
    MSW_SYS = 3'h4
  } msw_act_type;
  typedef struct packed {
    logic [3:0] stage_en;
    logic [3:0][2:0] stage_act;
    logic [3:0][31:0] stage_timeout;
    logic enable;
  } msw_cfg_type;
  typedef struct packed {
    logic irq;
    logic cpu_rst;
    logic core_rst;
    logic sys_rst;
  } msw_out_type;
endpackage

// ### logic/msw_core.sv
// One watchdog instance: four stages on a 32-bit expiry counter
`timescale 1ns/1ps
`include "msw_consts.svh"
module msw_core #(
  parameter bit SYS_RESET_OK = 1'b0,
  parameter bit BOOT_AUTO = 1'b0,
  parameter logic [31:0] BOOT_TIMEOUT = `MSW_BOOT_TIMEOUT_DEF
) (
  input wire logic mclk, // Clock
  input wire logic rst_b, // Async reset, low
  input wire logic flash_boot, // Flash boot in progress
  input wire logic boot_done, // Boot finished pulse
  input wire msw_pkg::msw_cfg_type cfg, // Active configuration
  input wire logic feed, // Feed pulse
  output msw_pkg::msw_out_type act, // Action pulses
  output logic [1:0] stage, // Current stage
  output logic running // Counting
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [1:0] next_stage;
  logic boot_guard;
  logic next_boot_guard;
  logic strap_seen;
  logic next_strap_seen;
  logic next_running;
  msw_pkg::msw_out_type next_act;
  logic [2:0] cur_act;

  always_comb begin
    next_cnt = cnt;
    next_stage = stage;
    next_act = '0;
    next_strap_seen = 1'b1;
    next_boot_guard = boot_guard;
    cur_act = cfg.stage_act[stage];
    if (!strap_seen && BOOT_AUTO && flash_boot) next_boot_guard = 1'b1;
    if (boot_done) next_boot_guard = 1'b0;
    next_running = cfg.enable || next_boot_guard;
    if (boot_guard) begin
      next_cnt = cnt + 32'h1;
      if (cnt >= BOOT_TIMEOUT) begin
        next_act.sys_rst = 1'b1;
        next_cnt = '0;
      end
    end else if (!running || feed) begin
      next_cnt = '0;
      next_stage = 2'h0;
    end else if (!cfg.stage_en[stage]) begin
      next_cnt = '0;
      next_stage = stage + 2'h1;
    end else if (cnt >= cfg.stage_timeout[stage]) begin
      next_cnt = '0;
      next_stage = stage + 2'h1;
      unique case (cur_act)
        `MSW_ACT_INT: next_act.irq = 1'b1;
        `MSW_ACT_CPU: next_act.cpu_rst = 1'b1;
        `MSW_ACT_CORE: next_act.core_rst = 1'b1;
        `MSW_ACT_SYS: next_act.sys_rst = SYS_RESET_OK;
        default: next_act = '0;
      endcase
    end else begin
      next_cnt = cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
      stage <= 2'h0;
      act <= '0;
      running <= 1'b0;
      boot_guard <= 1'b0;
      strap_seen <= 1'b0;
    end else begin
      cnt <= next_cnt;
      stage <= next_stage;
      act <= next_act;
      running <= next_running;
      boot_guard <= next_boot_guard;
      strap_seen <= next_strap_seen;
    end
  end

  feed_clears_a: assert property (@(posedge mclk) disable iff (!rst_b)
    feed && running && !boot_guard |=> cnt == 32'h0 && stage == 2'h0)
    else $error("feed did not restart watchdog");
  boot_reset_a: assert property (@(posedge mclk) disable iff (!rst_b)
    boot_guard && cnt >= BOOT_TIMEOUT |=> act.sys_rst)
    else $error("boot guard did not reset system");
  no_sys_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !SYS_RESET_OK |-> !act.sys_rst || $past(boot_guard))
    else $error("system reset from main watchdog stage");
  stage_act_a: assert property (@(posedge mclk) disable iff (!rst_b)
    running && !boot_guard && !feed && cfg.stage_en[stage] && cur_act == `MSW_ACT_INT
    && cnt >= cfg.stage_timeout[stage] |=> act.irq ##0 stage == $past(stage) + 2'h1)
    else $error("stage expiry action missing");
  skip_a: assert property (@(posedge mclk) disable iff (!rst_b)
    running && !boot_guard && !feed && !cfg.stage_en[stage] |=> !act.irq)
    else $error("disabled stage acted");
  count_a: assert property (@(posedge mclk) disable iff (!rst_b)
    running && !boot_guard && !feed && cfg.stage_en[stage] && cnt < cfg.stage_timeout[stage]
    |=> cnt == $past(cnt) + 32'h1)
    else $error("counter did not advance");
  stage_cov_c: cover property (@(posedge mclk) disable iff (!rst_b) stage == 2'h3);
  irq_cov_c: cover property (@(posedge mclk) disable iff (!rst_b) act.irq);
  boot_cov_c: cover property (@(posedge mclk) disable iff (!rst_b) boot_guard ##1 !boot_guard);
endmodule

// ### logic/msw_top.sv
// Three watchdog instances with per-watchdog write-lock configuration logic
`timescale 1ns/1ps
`include "msw_consts.svh"
// What this block does
// - three watchdogs: two main, one RTC domain
// - four stages, each its own timeout
// - each stage enabled or disabled separately
// - main expiry: interrupt, CPU or core reset
// - RTC watchdog may also reset system
// - configuration writes blocked unless lock released
// - flash boot auto-enables RTC and first group
// - boot overrun reboots whole main system
module msw_top #(
  parameter logic [31:0] BOOT_TIMEOUT = `MSW_BOOT_TIMEOUT_DEF,
  parameter logic [31:0] UNLOCK_KEY = `MSW_KEY
) (
  input wire logic mclk, // Clock 200 MHz
  input wire logic rst_b, // Async reset, low
  input wire logic flash_boot, // Booting from flash
  input wire logic boot_done, // Boot complete pulse
  input wire logic [31:0] key_data, // Write-protect key
  input wire logic key_wr, // Key write strobe
  input wire logic [1:0] cfg_sel, // Watchdog select 0/1 main, 2 RTC
  input wire logic cfg_wr, // Configuration write strobe
  input wire msw_pkg::msw_cfg_type cfg_data, // Configuration value
  input wire logic [2:0] feed, // Feed pulses
  output logic [2:0] locked, // Lock state per watchdog
  output logic [2:0] irq, // Interrupt per watchdog
  output logic cpu_rst, // CPU reset request
  output logic core_rst, // Core reset request
  output logic sys_rst, // System reset request
  output logic [5:0] stage // Stage per watchdog
);
  ////////////////////////////////////////////////////////////////////
  msw_pkg::msw_cfg_type cfg [3];
  msw_pkg::msw_cfg_type next_cfg [3];
  logic [2:0] next_locked;
  msw_pkg::msw_out_type act [3];
  logic [1:0] st [3];
  logic [2:0] run;
  logic [2:0] next_irq;
  logic next_cpu;
  logic next_core;
  logic next_sys;

  function automatic logic sel_hit(input logic [1:0] sel, input int idx);
    sel_hit = (sel == idx[1:0]);
  endfunction

  always_comb begin
    next_locked = locked;
    for (int i = 0; i < 3; i++) begin
      next_cfg[i] = cfg[i];
      if (key_wr && sel_hit(cfg_sel, i))
        next_locked[i] = (key_data != UNLOCK_KEY);
      if (cfg_wr && sel_hit(cfg_sel, i) && !locked[i])
        next_cfg[i] = cfg_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      locked <= 3'h7;
      for (int i = 0; i < 3; i++) begin
        cfg[i] <= '0;
      end
    end else begin
      locked <= next_locked;
      for (int i = 0; i < 3; i++) begin
        cfg[i] <= next_cfg[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Instances 0 and 1 are main watchdogs, 2 sits in the RTC domain
  msw_core #(
    .SYS_RESET_OK(1'b0),
    .BOOT_AUTO(1'b1),
    .BOOT_TIMEOUT(BOOT_TIMEOUT)
  ) u_main0 (
    .mclk(mclk),
    .rst_b(rst_b),
    .flash_boot(flash_boot),
    .boot_done(boot_done),
    .cfg(cfg[0]),
    .feed(feed[0]),
    .act(act[0]),
    .stage(st[0]),
    .running(run[0])
  );
  msw_core #(
    .SYS_RESET_OK(1'b0),
    .BOOT_AUTO(1'b0),
    .BOOT_TIMEOUT(BOOT_TIMEOUT)
  ) u_main1 (
    .mclk(mclk),
    .rst_b(rst_b),
    .flash_boot(flash_boot),
    .boot_done(boot_done),
    .cfg(cfg[1]),
    .feed(feed[1]),
    .act(act[1]),
    .stage(st[1]),
    .running(run[1])
  );
  msw_core #(
    .SYS_RESET_OK(1'b1),
    .BOOT_AUTO(1'b1),
    .BOOT_TIMEOUT(BOOT_TIMEOUT)
  ) u_rtc (
    .mclk(mclk),
    .rst_b(rst_b),
    .flash_boot(flash_boot),
    .boot_done(boot_done),
    .cfg(cfg[2]),
    .feed(feed[2]),
    .act(act[2]),
    .stage(st[2]),
    .running(run[2])
  );

  always_comb begin
    next_irq = {act[2].irq, act[1].irq, act[0].irq};
    next_cpu = act[0].cpu_rst | act[1].cpu_rst | act[2].cpu_rst;
    next_core = act[0].core_rst | act[1].core_rst | act[2].core_rst;
    next_sys = act[0].sys_rst | act[1].sys_rst | act[2].sys_rst;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 3'h0;
      cpu_rst <= 1'b0;
      core_rst <= 1'b0;
      sys_rst <= 1'b0;
      stage <= 6'h0;
    end else begin
      irq <= next_irq;
      cpu_rst <= next_cpu;
      core_rst <= next_core;
      sys_rst <= next_sys;
      stage <= {st[2], st[1], st[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Write protection, per watchdog
  locked_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_wr && cfg_sel == 2'h1 && locked[1] |=> cfg[1] == $past(cfg[1]))
    else $error("locked configuration changed");
  lock_keep0_a: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_wr && cfg_sel == 2'h0 && locked[0] |=> cfg[0] == $past(cfg[0]))
    else $error("locked configuration 0 changed");
  lock_keep2_a: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_wr && cfg_sel == 2'h2 && locked[2] |=> cfg[2] == $past(cfg[2]))
    else $error("locked configuration 2 changed");
  open_write0_a: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_wr && cfg_sel == 2'h0 && !locked[0] |=> cfg[0] == $past(cfg_data))
    else $error("open configuration 0 not written");
  open_write1_a: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_wr && cfg_sel == 2'h1 && !locked[1] |=> cfg[1] == $past(cfg_data))
    else $error("open configuration 1 not written");
  open_write2_a: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_wr && cfg_sel == 2'h2 && !locked[2] |=> cfg[2] == $past(cfg_data))
    else $error("open configuration 2 not written");
  unlock_a: assert property (@(posedge mclk) disable iff (!rst_b)
    key_wr && cfg_sel == 2'h0 && key_data == UNLOCK_KEY |=> !locked[0])
    else $error("key did not release lock");
  unlock1_a: assert property (@(posedge mclk) disable iff (!rst_b)
    key_wr && cfg_sel == 2'h1 && key_data == UNLOCK_KEY |=> !locked[1])
    else $error("key did not release lock 1");
  unlock2_a: assert property (@(posedge mclk) disable iff (!rst_b)
    key_wr && cfg_sel == 2'h2 && key_data == UNLOCK_KEY |=> !locked[2])
    else $error("key did not release lock 2");
  relock0_a: assert property (@(posedge mclk) disable iff (!rst_b)
    key_wr && cfg_sel == 2'h0 && key_data != UNLOCK_KEY |=> locked[0])
    else $error("wrong key left lock 0 open");
  relock1_a: assert property (@(posedge mclk) disable iff (!rst_b)
    key_wr && cfg_sel == 2'h1 && key_data != UNLOCK_KEY |=> locked[1])
    else $error("wrong key left lock 1 open");
  relock2_a: assert property (@(posedge mclk) disable iff (!rst_b)
    key_wr && cfg_sel == 2'h2 && key_data != UNLOCK_KEY |=> locked[2])
    else $error("wrong key left lock 2 open");
  lock_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !key_wr |=> locked == $past(locked))
    else $error("lock changed without key write");
  spare_key_a: assert property (@(posedge mclk) disable iff (!rst_b)
    key_wr && cfg_sel == 2'h3 |=> locked == $past(locked))
    else $error("unused select changed a lock");
  spare_sel_a: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_wr && cfg_sel == 2'h3
    |=> cfg[0] == $past(cfg[0]) && cfg[1] == $past(cfg[1]) && cfg[2] == $past(cfg[2]))
    else $error("unused select changed a configuration");

  // Outputs of each watchdog as seen at the pins
  main1_nosys_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !act[1].sys_rst)
    else $error("second main watchdog asked for system reset");
  rtc_sys_a: assert property (@(posedge mclk) disable iff (!rst_b)
    act[2].sys_rst |=> sys_rst)
    else $error("RTC system reset not passed out");
  idle_quiet0_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !run[0] |-> ##2 !irq[0])
    else $error("idle watchdog 0 raised interrupt");
  idle_quiet1_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !run[1] |-> ##2 !irq[1])
    else $error("idle watchdog 1 raised interrupt");
  idle_quiet2_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !run[2] |-> ##2 !irq[2])
    else $error("idle watchdog 2 raised interrupt");
  feed_stage0_a: assert property (@(posedge mclk) disable iff (!rst_b)
    feed[0] && run[0] |-> ##2 stage[1:0] == 2'h0)
    else $error("feed did not return watchdog 0 to first stage");
  feed_stage1_a: assert property (@(posedge mclk) disable iff (!rst_b)
    feed[1] && run[1] |-> ##2 stage[3:2] == 2'h0)
    else $error("feed did not return watchdog 1 to first stage");
  feed_stage2_a: assert property (@(posedge mclk) disable iff (!rst_b)
    feed[2] && run[2] |-> ##2 stage[5:4] == 2'h0)
    else $error("feed did not return watchdog 2 to first stage");
  unlock_cov_c: cover property (@(posedge mclk) disable iff (!rst_b) !locked[2] ##1 cfg_wr);
  sys_cov_c: cover property (@(posedge mclk) disable iff (!rst_b) sys_rst);
endmodule

// ### dv/msw_top_tb.sv
// Self-checking bench for the three-instance multi-stage watchdog
`timescale 1ns/1ps
`include "msw_consts.svh"
module multi_stage_watchdog_tb_top;
  localparam logic [2:0] AN = msw_pkg::MSW_NONE;
  localparam logic [2:0] AI = msw_pkg::MSW_INT;
  localparam logic [2:0] AC = msw_pkg::MSW_CPU;
  localparam logic [2:0] AR = msw_pkg::MSW_CORE;
  localparam logic [2:0] AS = msw_pkg::MSW_SYS;
  logic mclk = 0, rst_b = 0, flash_boot = 0, boot_done = 0, key_wr = 0, cfg_wr = 0;
  logic [31:0] key_data = 0;
  logic [1:0] cfg_sel = 0;
  logic [2:0] feed = 0, locked, irq;
  logic cpu_rst, core_rst, sys_rst;
  logic [5:0] stage;
  msw_pkg::msw_cfg_type cfg_data = '0;
  int error_cnt = 0, checks = 0, cyc = 0, got[$];
  logic [31:0] seed = 32'h0000_7736;
  always #2.5 mclk = ~mclk;
  msw_top #(.BOOT_TIMEOUT(32'h0000_0064)) i_dut (.mclk(mclk), .rst_b(rst_b),
    .flash_boot(flash_boot), .boot_done(boot_done), .key_data(key_data), .key_wr(key_wr),
    .cfg_sel(cfg_sel), .cfg_wr(cfg_wr), .cfg_data(cfg_data), .feed(feed), .locked(locked),
    .irq(irq), .cpu_rst(cpu_rst), .core_rst(core_rst), .sys_rst(sys_rst), .stage(stage));
  ////////////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function msw_pkg::msw_cfg_type mk(logic [3:0] en, logic [11:0] a, logic [31:0] t);
    mk.enable = |en;
    mk.stage_en = en;
    mk.stage_act = a;
    mk.stage_timeout = {t + 32'h3, t + 32'h2, t + 32'h1, t};
  endfunction
  task stop_test();
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(logic ok, string m);
    checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // Observed action pulses against the expected sequence, in order
  task cmp(int e[$]);
    chk(got.size() == e.size(), "event count");
    foreach (e[i]) if (i < got.size()) chk(got[i] == e[i], "event order");
    got.delete();
  endtask
  task wait_ev(int n, int lim);
    repeat (lim) if (got.size() < n) @(posedge mclk);
  endtask
  task cfgw(logic [1:0] s, msw_pkg::msw_cfg_type c, logic [31:0] k);
    @(posedge mclk); cfg_sel <= s; key_data <= k; key_wr <= 1;
    @(posedge mclk); key_wr <= 0; cfg_data <= c; cfg_wr <= 1;
    @(posedge mclk); cfg_wr <= 0;
    @(posedge mclk);
    chk(locked[s] === (k != `MSW_KEY), "lock state");
  endtask
  task rst(logic fb);
    rst_b <= 0;
    flash_boot <= fb;
    repeat (4) @(posedge mclk);
    rst_b <= 1;
    got.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) if (rst_b === 1'b1) begin
    for (int i = 0; i < 3; i++) if (irq[i] === 1'b1) got.push_back(i);
    if (cpu_rst === 1'b1) got.push_back(4);
    if (core_rst === 1'b1) got.push_back(5);
    if (sys_rst === 1'b1) got.push_back(6);
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    logic [31:0] t;
    rst(0);
    chk(locked === 3'b111 && irq === 3'b000 && stage === 6'h00, "reset state");
    @(posedge mclk); cfg_data <= mk(4'h1, {4{AI}}, 32'h5); cfg_wr <= 1;
    @(posedge mclk); cfg_wr <= 0;
    repeat (60) @(posedge mclk);
    cmp('{});
    t = 32'h8 + rnd() % 32'h10;
    cfgw(0, mk(4'hb, {AR, AR, AC, AI}, t), `MSW_KEY);
    wait_ev(3, 400);
    cfgw(0, mk(4'h0, 12'h000, t), `MSW_KEY);
    cmp('{0, 4, 5});
    cfgw(0, mk(4'h1, {4{AI}}, t), `MSW_KEY);
    repeat (30) begin
      repeat (4) @(posedge mclk);
      chk(stage === 6'h00, "stage held");
      feed <= 3'b001;
      @(posedge mclk);
      feed <= 3'b000;
    end
    cmp('{});
    wait_ev(1, 100);
    cfgw(0, mk(4'h0, 12'h000, t), `MSW_KEY);
    cmp('{0});
    cfgw(0, mk(4'h1, {4{AI}}, 32'h5), `MSW_KEY ^ 32'h1);
    repeat (60) @(posedge mclk);
    cmp('{});
    cfgw(1, mk(4'h3, {AN, AN, AI, AS}, t), `MSW_KEY);
    wait_ev(1, 200);
    cfgw(1, mk(4'h0, 12'h000, t), `MSW_KEY);
    cmp('{1});
    cfgw(2, mk(4'h1, {4{AS}}, t), `MSW_KEY);
    wait_ev(1, 200);
    cfgw(2, mk(4'h0, 12'h000, t), `MSW_KEY);
    cmp('{6});
    // Flash boot with no completion, then completion silences the guard
    rst(1);
    wait_ev(1, 300);
    chk(got.size() > 0, "boot guard");
    @(posedge mclk); boot_done <= 1; flash_boot <= 0;
    @(posedge mclk); boot_done <= 0;
    repeat (4) @(posedge mclk);
    foreach (got[i]) chk(got[i] == 6, "boot action");
    got.delete();
    repeat (400) @(posedge mclk);
    cmp('{});
    stop_test();
  end
endmodule
